// ===== hdl/uip_regs.svh
// Offsets, field positions, reset values and timing counts
`ifndef UIP_REGS_SVH
`define UIP_REGS_SVH

`define UIP_ADDR_W          4
`define UIP_OFF_MASK        4'h1
`define UIP_OFF_SOURCE      4'h2
`define UIP_OFF_FIFO_CTL    4'h2
`define UIP_OFF_MODEM_CTL   4'h4
`define UIP_OFF_LINE_STAT   4'h5
`define UIP_OFF_MODEM_STAT  4'h6
`define UIP_OFF_FEATURE     4'h8
`define UIP_OFF_ENHANCED    4'h9
`define UIP_OFF_RX_TRIG     4'hA
`define UIP_OFF_TX_TRIG     4'hB
`define UIP_OFF_DEV_INT     4'hC

`define UIP_MASK_RX         0
`define UIP_MASK_TX         1
`define UIP_MASK_LSR        2
`define UIP_MASK_MSR        3
`define UIP_MASK_SPEC       5
`define UIP_MASK_RTS        6
`define UIP_MASK_CTS        7
`define UIP_FCR_EN          0
`define UIP_FCR_RX_LSB      6
`define UIP_FCR_TX_LSB      4
`define UIP_FEATURE_CONTROL_REG_TBL_LSB    6
`define UIP_FEATURE_CONTROL_REG_RS485      5
`define UIP_EFR_ENH         4
`define UIP_EFR_AUTO_RTS    6
`define UIP_EFR_AUTO_CTS    7
`define UIP_MCR_DSR_SEL     2

`define UIP_RST_BYTE        8'h00
`define UIP_RST_SEL         2'h0

// Trigger tables, one byte per selection except table A transmit (one byte for all), selection 0 in low byte
`define UIP_TRIG_A_RX       32'h0E080401
`define UIP_TRIG_A_TX       8'h01
`define UIP_TRIG_B_RX       32'h1C181008
`define UIP_TRIG_B_TX       32'h1E180810
`define UIP_TRIG_C_RX       32'h3C381008
`define UIP_TRIG_C_TX       32'h38201008

// Receive timeout in character times and bit times
`define UIP_TO_CHARS        4
`define UIP_TO_BITS         12

`endif

// ===== hdl/uip_pkg.sv
// Types of the interrupt prioritizer
package uip_pkg;

	typedef enum logic [7:0] {
		SRC_NONE  = 8'h01,
		SRC_LSR   = 8'h02,
		SRC_RECEIVE_READY_IRQ = 8'h04,
		SRC_RXTO  = 8'h08,
		SRC_TRANSMIT_READY_IRQ = 8'h10,
		SRC_MSR   = 8'h20,
		SRC_SPEC  = 8'h40,
		SRC_FLOW  = 8'h80
	} uip_src_t;

	typedef enum logic [1:0] {
		TBL_A = 2'h0,
		TBL_B = 2'h1,
		TBL_C = 2'h2,
		TBL_D = 2'h3
	} uip_tbl_t;

endpackage : uip_pkg

// ===== hdl/uip_prioritizer.sv
// UART channel interrupt prioritizer with trigger selection
`timescale 1ns/100ps
`default_nettype none
`include "uip_regs.svh"

module uip_prioritizer
	import uip_pkg::*;
#(
	parameter int CNT_W = 9
) (
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic [3:0]        addr_in,
	input  wire logic [7:0]        wr_data_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [7:0]        rd_data_out,
	input  wire logic              rx_push_in,
	input  wire logic [3:0]        rx_push_err_in,
	input  wire logic [3:0]        head_err_in,
	input  wire logic              fifo_err_in,
	input  wire logic              rx_pop_in,
	input  wire logic [CNT_W-1:0]  rx_count_in,
	input  wire logic              tx_push_in,
	input  wire logic [CNT_W-1:0]  tx_count_in,
	input  wire logic              tsr_empty_in,
	input  wire logic              bit_tick_in,
	input  wire logic [3:0]        char_bits_in,
	input  wire logic [3:0]        modem_delta_in,
	input  wire logic [3:0]        modem_state_in,
	input  wire logic              cts_pin_in,
	input  wire logic              dsr_pin_in,
	input  wire logic              rts_state_in,
	input  wire logic              dtr_state_in,
	input  wire logic              special_det_in,
	input  wire logic              wake_in,
	output logic                   fifo_en_out,
	output logic                   irq_out,
	output logic                   wake_irq_out
);

	if (CNT_W < 7 || CNT_W > 16) begin : g_chk
		$error("CNT_W must hold trigger levels, 7 to 16 bits");
	end

	////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [7:0] trig_lvl(input logic [1:0] tbl,
		input logic [1:0] sel, input logic tx, input logic [7:0] prog);
		logic [31:0] row;
		logic [7:0]  lvl;
		row = 32'h00000000;
		case (tbl)
			TBL_A: row = tx ? {4{`UIP_TRIG_A_TX}} : `UIP_TRIG_A_RX;
			TBL_B: row = tx ? `UIP_TRIG_B_TX : `UIP_TRIG_B_RX;
			TBL_C: row = tx ? `UIP_TRIG_C_TX : `UIP_TRIG_C_RX;
			default: row = {4{prog}};
		endcase
		lvl = row[sel*8 +: 8];
		return lvl;
	endfunction : trig_lvl

	function automatic logic [5:0] src_code(input uip_src_t s);
		logic [5:0] c;
		c = 6'h01;
		case (s)
			SRC_LSR:   c = 6'h06;
			SRC_RECEIVE_READY_IRQ: c = 6'h04;
			SRC_RXTO:  c = 6'h0C;
			SRC_TRANSMIT_READY_IRQ: c = 6'h02;
			SRC_MSR:   c = 6'h00;
			SRC_SPEC:  c = 6'h10;
			SRC_FLOW:  c = 6'h20;
			default:   c = 6'h01;
		endcase
		return c;
	endfunction : src_code

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0]       mask_q;
	logic [7:0]       mcr_q;
	logic [7:0]       feature_control_reg_q;
	logic [7:0]       efr_q;
	logic [7:0]       rx_prog_q;
	logic [7:0]       tx_prog_q;
	logic [1:0]       rx_sel_q;
	logic [1:0]       tx_sel_q;
	logic             fifo_en_q;
	logic             rd_ls;
	logic             rd_ms;
	logic             rd_src;
	logic             rd_dev;
	logic [7:0]       rx_trig;
	logic [7:0]       tx_trig;
	logic [7:0]       line_stat;
	logic [3:0]       delta_q;
	uip_src_t         cur_q;

	assign rd_ls  = rd_in && addr_in == `UIP_OFF_LINE_STAT;
	assign rd_ms  = rd_in && addr_in == `UIP_OFF_MODEM_STAT;
	assign rd_src = rd_in && addr_in == `UIP_OFF_SOURCE;
	assign rd_dev = rd_in && addr_in == `UIP_OFF_DEV_INT;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mask_q    <= `UIP_RST_BYTE;
			mcr_q     <= `UIP_RST_BYTE;
			feature_control_reg_q    <= `UIP_RST_BYTE;
			efr_q     <= `UIP_RST_BYTE;
			rx_prog_q <= `UIP_RST_BYTE;
			tx_prog_q <= `UIP_RST_BYTE;
		end else if (wr_in) begin
			if (addr_in == `UIP_OFF_MASK) begin
				mask_q <= wr_data_in;
			end else if (addr_in == `UIP_OFF_MODEM_CTL) begin
				mcr_q <= wr_data_in;
			end else if (addr_in == `UIP_OFF_FEATURE) begin
				feature_control_reg_q <= wr_data_in;
			end else if (addr_in == `UIP_OFF_ENHANCED) begin
				efr_q <= wr_data_in;
			end else if (addr_in == `UIP_OFF_RX_TRIG) begin
				rx_prog_q <= wr_data_in;
			end else if (addr_in == `UIP_OFF_TX_TRIG) begin
				tx_prog_q <= wr_data_in;
			end
		end
	end

	// FIFO control: trigger selections load only with the enable bit written as one; transmit also needs the EFR enhanced bit
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fifo_en_q <= 1'b0;
			rx_sel_q  <= `UIP_RST_SEL;
			tx_sel_q  <= `UIP_RST_SEL;
		end else if (wr_in && addr_in == `UIP_OFF_FIFO_CTL) begin
			fifo_en_q <= wr_data_in[`UIP_FCR_EN];
			if (wr_data_in[`UIP_FCR_EN]) begin
				rx_sel_q <= wr_data_in[`UIP_FCR_RX_LSB +: 2];
				if (efr_q[`UIP_EFR_ENH]) begin
					tx_sel_q <= wr_data_in[`UIP_FCR_TX_LSB +: 2];
				end
			end
		end
	end

	// One table serves both directions
	assign rx_trig = trig_lvl(feature_control_reg_q[`UIP_FEATURE_CONTROL_REG_TBL_LSB +: 2], rx_sel_q,
		1'b0, rx_prog_q);
	assign tx_trig = trig_lvl(feature_control_reg_q[`UIP_FEATURE_CONTROL_REG_TBL_LSB +: 2], tx_sel_q,
		1'b1, tx_prog_q);

	// Error bits follow the head character only; bit 7 flags the FIFO
	assign line_stat = {fifo_err_in, tx_count_in == '0 && tsr_empty_in,
		tx_count_in == '0, head_err_in, rx_count_in != '0};

	////////////////////////////////////////////////////////////////////////
	// Line status and receive sources

	logic             lsr_pend_q;
	logic             head_bad_q;
	logic             lsr_set;
	logic             rx_lvl;
	logic             to_pend_q;
	logic [7:0]       to_cnt_q;
	logic [7:0]       to_lim;

	assign lsr_set = (rx_push_in && rx_push_err_in != 4'h0)
		|| (head_err_in != 4'h0 && !head_bad_q);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			lsr_pend_q <= 1'b0;
			head_bad_q <= 1'b0;
		end else begin
			head_bad_q <= head_err_in != 4'h0;
			if (lsr_set) begin
				lsr_pend_q <= 1'b1;
			end else if (rd_ls) begin
				lsr_pend_q <= 1'b0;
			end
		end
	end

	assign rx_lvl = fifo_en_q ? rx_count_in >= CNT_W'(rx_trig)
		: rx_count_in != '0;
	assign to_lim = 8'(`UIP_TO_CHARS * char_bits_in + `UIP_TO_BITS);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			to_cnt_q  <= 8'h00;
			to_pend_q <= 1'b0;
		end else begin
			if (rx_push_in || rx_pop_in) begin
				to_cnt_q <= 8'h00;
			end else if (fifo_en_q && bit_tick_in && rx_count_in != '0
				&& !rx_lvl && to_cnt_q < to_lim) begin
				to_cnt_q <= to_cnt_q + 8'h01;
			end
			if (rx_pop_in) begin
				to_pend_q <= 1'b0;
			end else if (fifo_en_q && to_cnt_q == to_lim
				&& rx_count_in != '0 && !rx_lvl) begin
				to_pend_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit ready

	logic             tx_pend_q;
	logic             tx_empty_q;
	logic             tx_below_q;
	logic             tx_reached_q;
	logic             tx_empty;
	logic             tx_below;
	logic             tx_set;

	assign tx_empty = tx_count_in == '0 && (!fifo_en_q
		|| !feature_control_reg_q[`UIP_FEATURE_CONTROL_REG_RS485] || tsr_empty_in);
	assign tx_below = tx_count_in < CNT_W'(tx_trig);
	assign tx_set = (tx_empty && !tx_empty_q)
		|| (fifo_en_q && tx_reached_q && tx_below && !tx_below_q);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tx_pend_q    <= 1'b0;
			tx_empty_q   <= 1'b1;
			tx_below_q   <= 1'b1;
			tx_reached_q <= 1'b0;
		end else begin
			tx_empty_q <= tx_empty;
			tx_below_q <= tx_below;
			if (!tx_below) begin
				tx_reached_q <= 1'b1;
			end else if (tx_set) begin
				tx_reached_q <= 1'b0;
			end
			if (tx_set) begin
				tx_pend_q <= 1'b1;
			end else if (tx_push_in || (rd_src && cur_q == SRC_TRANSMIT_READY_IRQ)) begin
				tx_pend_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Modem, flow pins, special character and wake-up

	logic [2:0]       cts_s_q;
	logic [2:0]       dsr_s_q;
	logic             cts_f_q;
	logic             dsr_f_q;
	logic             rts_p_q;
	logic             dtr_p_q;
	logic             in_rise;
	logic             out_rise;
	logic             flow_pend_q;
	logic             spec_pend_q;
	logic             wake_q;
	logic             dsr_sel;

	assign dsr_sel = mcr_q[`UIP_MCR_DSR_SEL];

	// Pins pass three flops; a level counts once the last two agree
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cts_s_q <= 3'h0;
			dsr_s_q <= 3'h0;
			cts_f_q <= 1'b0;
			dsr_f_q <= 1'b0;
			rts_p_q <= 1'b0;
			dtr_p_q <= 1'b0;
		end else begin
			cts_s_q <= {cts_s_q[1:0], cts_pin_in};
			dsr_s_q <= {dsr_s_q[1:0], dsr_pin_in};
			if (cts_s_q[1] == cts_s_q[2]) begin
				cts_f_q <= cts_s_q[2];
			end
			if (dsr_s_q[1] == dsr_s_q[2]) begin
				dsr_f_q <= dsr_s_q[2];
			end
			rts_p_q <= rts_state_in;
			dtr_p_q <= dtr_state_in;
		end
	end

	assign in_rise = efr_q[`UIP_EFR_AUTO_CTS] && (dsr_sel
		? (dsr_s_q[1] == dsr_s_q[2] && dsr_s_q[2] && !dsr_f_q)
		: (cts_s_q[1] == cts_s_q[2] && cts_s_q[2] && !cts_f_q));
	assign out_rise = efr_q[`UIP_EFR_AUTO_RTS] && (dsr_sel
		? (dtr_state_in && !dtr_p_q)
		: (rts_state_in && !rts_p_q));

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			delta_q     <= 4'h0;
			flow_pend_q <= 1'b0;
			spec_pend_q <= 1'b0;
			wake_q      <= 1'b0;
		end else begin
			delta_q <= (rd_ms ? 4'h0 : delta_q) | modem_delta_in;
			if (in_rise || out_rise) begin
				flow_pend_q <= 1'b1;
			end else if (rd_ms) begin
				flow_pend_q <= 1'b0;
			end
			if (special_det_in) begin
				spec_pend_q <= 1'b1;
			end else if (rd_src && cur_q == SRC_SPEC) begin
				spec_pend_q <= 1'b0;
			end
			if (wake_in) begin
				wake_q <= 1'b1;
			end else if (rd_dev) begin
				wake_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prioritizer

	uip_src_t         cur_d;
	logic [6:0]       act;
	logic             cur_live;
	logic             enh;

	assign enh = efr_q[`UIP_EFR_ENH];
	assign act = {
		flow_pend_q && enh && (mask_q[`UIP_MASK_CTS] || mask_q[`UIP_MASK_RTS]),
		spec_pend_q && enh && mask_q[`UIP_MASK_SPEC],
		delta_q != 4'h0 && mask_q[`UIP_MASK_MSR],
		tx_pend_q && mask_q[`UIP_MASK_TX],
		to_pend_q && mask_q[`UIP_MASK_RX],
		rx_lvl && mask_q[`UIP_MASK_RX],
		lsr_pend_q && mask_q[`UIP_MASK_LSR]
	};

	always_comb begin
		cur_live = 1'b0;
		case (cur_q)
			SRC_LSR:   cur_live = act[0];
			SRC_RECEIVE_READY_IRQ: cur_live = act[1];
			SRC_RXTO:  cur_live = act[2];
			SRC_TRANSMIT_READY_IRQ: cur_live = act[3];
			SRC_MSR:   cur_live = act[4];
			SRC_SPEC:  cur_live = act[5];
			SRC_FLOW:  cur_live = act[6];
			default:   cur_live = 1'b0;
		endcase
	end

	// Current source holds until serviced, then highest wins
	always_comb begin
		cur_d = SRC_NONE;
		if (cur_live) begin
			cur_d = cur_q;
		end else if (act[0]) begin
			cur_d = SRC_LSR;
		end else if (act[1]) begin
			cur_d = SRC_RECEIVE_READY_IRQ;
		end else if (act[2]) begin
			cur_d = SRC_RXTO;
		end else if (act[3]) begin
			cur_d = SRC_TRANSMIT_READY_IRQ;
		end else if (act[4]) begin
			cur_d = SRC_MSR;
		end else if (act[5]) begin
			cur_d = SRC_SPEC;
		end else if (act[6]) begin
			cur_d = SRC_FLOW;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cur_q        <= SRC_NONE;
			irq_out      <= 1'b0;
			wake_irq_out <= 1'b0;
			fifo_en_out  <= 1'b0;
		end else begin
			cur_q        <= cur_d;
			irq_out      <= cur_d != SRC_NONE;
			wake_irq_out <= wake_in || (wake_q && !rd_dev);
			fifo_en_out  <= fifo_en_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rd_data_out <= 8'h00;
		end else if (!rd_in) begin
			rd_data_out <= 8'h00;
		end else if (addr_in == `UIP_OFF_MASK) begin
			rd_data_out <= mask_q;
		end else if (addr_in == `UIP_OFF_SOURCE) begin
			rd_data_out <= {{2{fifo_en_q}}, src_code(cur_q)};
		end else if (addr_in == `UIP_OFF_MODEM_CTL) begin
			rd_data_out <= mcr_q;
		end else if (addr_in == `UIP_OFF_LINE_STAT) begin
			rd_data_out <= line_stat;
		end else if (addr_in == `UIP_OFF_MODEM_STAT) begin
			rd_data_out <= {modem_state_in, delta_q | modem_delta_in};
		end else if (addr_in == `UIP_OFF_FEATURE) begin
			rd_data_out <= feature_control_reg_q;
		end else if (addr_in == `UIP_OFF_ENHANCED) begin
			rd_data_out <= efr_q;
		end else if (addr_in == `UIP_OFF_RX_TRIG) begin
			rd_data_out <= rx_prog_q;
		end else if (addr_in == `UIP_OFF_TX_TRIG) begin
			rd_data_out <= tx_prog_q;
		end else if (addr_in == `UIP_OFF_DEV_INT) begin
			rd_data_out <= {6'h00, wake_q, cur_q != SRC_NONE};
		end else begin
			rd_data_out <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	a_src_fifo_bits: assert property (@(posedge clk_in) disable iff (reset_in)
		rd_src |=> rd_data_out[7:6] == {2{$past(fifo_en_q)}})
		else $error("source bits 7:6 do not follow FIFO enable");
	a_src_none_bit: assert property (@(posedge clk_in) disable iff (reset_in)
		rd_src |=> rd_data_out[0] == ($past(cur_q) == SRC_NONE))
		else $error("source bit 0 wrong");
	a_hold_current: assert property (@(posedge clk_in) disable iff (reset_in)
		cur_q != SRC_NONE && cur_live |=> cur_q == $past(cur_q))
		else $error("pending source replaced before service");
	a_lsr_on_err: assert property (@(posedge clk_in) disable iff (reset_in)
		rx_push_in && rx_push_err_in != 4'h0 |=> lsr_pend_q)
		else $error("errored character raised no line status");
	a_lsr_read_clr: assert property (@(posedge clk_in) disable iff (reset_in)
		rd_ls && !lsr_set |=> !lsr_pend_q)
		else $error("line status read did not clear");
	a_lsr_masked: assert property (@(posedge clk_in) disable iff (reset_in)
		!mask_q[`UIP_MASK_LSR] && $past(!mask_q[`UIP_MASK_LSR])
		|-> cur_q != SRC_LSR)
		else $error("masked line status presented");
	a_timeout_clr: assert property (@(posedge clk_in) disable iff (reset_in)
		rx_pop_in |=> !to_pend_q ##1 to_cnt_q <= 8'h01)
		else $error("receive read did not clear timeout");
	a_special_set: assert property (@(posedge clk_in) disable iff (reset_in)
		special_det_in |=> spec_pend_q)
		else $error("special character not flagged");
	a_wake_out: assert property (@(posedge clk_in) disable iff (reset_in)
		wake_in ##1 !rd_dev |=> wake_irq_out)
		else $error("wake-up indicator lost");
	a_tx_write_clr: assert property (@(posedge clk_in) disable iff (reset_in)
		tx_push_in && !tx_set |=> !tx_pend_q)
		else $error("transmit write did not clear ready");

endmodule : uip_prioritizer

`default_nettype wire

// ===== verif/uip_prioritizer_bench.sv
// Self-checking bench of the interrupt prioritizer
`timescale 1ns/100ps
`default_nettype none
`include "uip_regs.svh"

module uip_prioritizer_bench;

	logic        clk_in = 1'b0;
	logic        reset_in;
	logic [3:0]  addr_in;
	logic [7:0]  wr_data_in;
	logic        wr_in;
	logic        rd_in;
	logic [3:0]  rx_push_err_in;
	logic [8:0]  rx_count_in;
	logic [8:0]  tx_count_in;
	logic        tsr_empty_in;
	logic        bit_tick_in;
	logic        tick_en;
	logic [3:0]  char_bits_in;
	logic [3:0]  delta;
	logic [3:0]  modem_state_in;
	logic        rts_state_in;
	logic [5:0]  pls;
	logic [31:0] seed = 32'h0000005A;
	logic [7:0]  rd_data_out;
	logic        fifo_en_out;
	logic        irq_out;
	logic        wake_irq_out;
	logic [3:0]  e;
	logic [3:0]  head_err;
	logic        fifo_err;
	logic        cts_pin;
	int          err_count = 0;
	int          n_tests = 0;
	int          n;
	int          lim;

	always #12.5 clk_in = ~clk_in;
	always @(posedge clk_in) bit_tick_in <= tick_en;

	uip_prioritizer u_uip_prioritizer (
		.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
		.rd_data_out(rd_data_out), .rx_push_in(pls[0]),
		.rx_push_err_in(rx_push_err_in), .head_err_in(head_err),
		.fifo_err_in(fifo_err), .rx_pop_in(pls[1]), .rx_count_in(rx_count_in),
		.tx_push_in(pls[2]), .tx_count_in(tx_count_in),
		.tsr_empty_in(tsr_empty_in), .bit_tick_in(bit_tick_in),
		.char_bits_in(char_bits_in),
		.modem_delta_in(pls[5] ? delta : 4'h0),
		.modem_state_in(modem_state_in), .cts_pin_in(cts_pin),
		.dsr_pin_in(1'b0), .rts_state_in(rts_state_in),
		.dtr_state_in(1'b0), .special_det_in(pls[3]), .wake_in(pls[4]),
		.fifo_en_out(fifo_en_out), .irq_out(irq_out),
		.wake_irq_out(wake_irq_out)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	function automatic int trig_a(input int sel);
		case (sel)
			0: return 1;
			1: return 4;
			2: return 8;
			default: return 14;
		endcase
	endfunction : trig_a

	function automatic int to_lim(input int cb);
		return 4 * cb + 12;
	endfunction : to_lim

	function automatic logic [7:0] lsr_exp(input logic fe,
		input logic [3:0] er, input logic rx);
		// Transmitter idle: holding and shift register both empty
		return {fe, 2'b11, er, rx};
	endfunction : lsr_exp

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic check_byte(input string nm, input logic [7:0] x, g);
		n_tests++;
		if (g !== x) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask : check_byte

	task automatic check_bit(input string nm, input logic x, g);
		n_tests++;
		if (g !== x) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", nm, x, g);
		end
	endtask : check_bit

	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask : tick

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] x);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		check_byte("read data", x, rd_data_out);
	endtask : rd_chk

	task automatic pulse(input logic [5:0] p);
		@(posedge clk_in);
		pls <= p;
		@(posedge clk_in);
		pls <= 6'h00;
		tick(3);
	endtask : pulse

	task automatic set_rx(input int c);
		@(posedge clk_in);
		rx_count_in <= 9'(c);
		tick(4);
	endtask : set_rx

	task automatic trig_chk(input int lvl);
		set_rx(lvl - 1);
		check_bit("below trigger", 1'b0, irq_out);
		set_rx(lvl);
		check_bit("at trigger", 1'b1, irq_out);
		rd_chk(`UIP_OFF_SOURCE, 8'hC4);
		set_rx(0);
		check_bit("trigger cleared", 1'b0, irq_out);
	endtask : trig_chk

	////////////////////////////////////////////////////////////////////////
	initial begin
		{addr_in, wr_data_in, wr_in, rd_in, rx_push_err_in} = '0;
		{rx_count_in, tx_count_in, tick_en, pls, rts_state_in} = '0;
		{head_err, fifo_err, cts_pin} = '0;
		tsr_empty_in = 1'b1;
		char_bits_in = 4'hA;
		delta = 4'h1;
		modem_state_in = 4'h0;
		reset_in = 1'b1;
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		tick(1);
		check_bit("irq at reset", 1'b0, irq_out);
		check_bit("fifo at reset", 1'b0, fifo_en_out);
		rd_chk(`UIP_OFF_SOURCE, 8'h01);
		rd_chk(`UIP_OFF_MASK, 8'h00);
		rx_push_err_in <= 4'h2;
		pulse(6'h01);
		check_bit("masked error", 1'b0, irq_out);
		rd_chk(`UIP_OFF_SOURCE, 8'h01);
		rd_chk(`UIP_OFF_LINE_STAT, lsr_exp(1'b0, 4'h0, 1'b0));
		wr_reg(`UIP_OFF_MASK, 8'h0C);
		for (int i = 0; i < 5; i++) begin
			seed = xs(seed);
			e = (i < 4) ? 4'(1 << i) : (seed[3:0] | 4'h1);
			rx_push_err_in <= e;
			modem_state_in <= seed[7:4];
			pulse(6'h01);
			check_bit("error irq", 1'b1, irq_out);
			rd_chk(`UIP_OFF_SOURCE, 8'h06);
			rd_chk(`UIP_OFF_LINE_STAT, lsr_exp(1'b0, 4'h0, 1'b0));
			tick(2);
			rd_chk(`UIP_OFF_SOURCE, 8'h01);
		end
		@(posedge clk_in) fifo_err <= 1'b1;
		tick(4);
		check_bit("no head irq", 1'b0, irq_out);
		rd_chk(`UIP_OFF_LINE_STAT, lsr_exp(1'b1, 4'h0, 1'b0));
		@(posedge clk_in) head_err <= e;
		tick(4);
		rd_chk(`UIP_OFF_SOURCE, 8'h06);
		rd_chk(`UIP_OFF_LINE_STAT, lsr_exp(1'b1, e, 1'b0));
		@(posedge clk_in) {head_err, fifo_err} <= 5'h00;
		tick(2);
		rd_chk(`UIP_OFF_SOURCE, 8'h01);
		delta <= seed[11:8] | 4'h8;
		pulse(6'h20);
		rd_chk(`UIP_OFF_SOURCE, 8'h00);
		rd_chk(`UIP_OFF_MODEM_STAT, {modem_state_in, delta});
		tick(2);
		rd_chk(`UIP_OFF_SOURCE, 8'h01);
		pulse(6'h10);
		check_bit("wake irq", 1'b1, wake_irq_out);
		rd_chk(`UIP_OFF_DEV_INT, 8'h02);
		tick(2);
		check_bit("wake cleared", 1'b0, wake_irq_out);
		wr_reg(`UIP_OFF_FIFO_CTL, 8'h01);
		tick(2);
		check_bit("fifo enable", 1'b1, fifo_en_out);
		rd_chk(`UIP_OFF_SOURCE, 8'hC1);
		wr_reg(`UIP_OFF_MASK, 8'h01);
		for (int s = 0; s < 4; s++) begin
			wr_reg(`UIP_OFF_FIFO_CTL, {2'(s), 6'h01});
			trig_chk(trig_a(s));
		end
		wr_reg(`UIP_OFF_MASK, 8'h07);
		@(posedge clk_in) tx_count_in <= 9'h001;
		@(posedge clk_in) tx_count_in <= 9'h000;
		rx_push_err_in <= 4'h4;
		pulse(6'h01);
		rd_chk(`UIP_OFF_SOURCE, 8'hC2);
		tick(2);
		rd_chk(`UIP_OFF_SOURCE, 8'hC6);
		rd_chk(`UIP_OFF_LINE_STAT, lsr_exp(1'b0, 4'h0, 1'b0));
		tick(2);
		rd_chk(`UIP_OFF_SOURCE, 8'hC1);
		@(posedge clk_in) tx_count_in <= 9'h001;
		@(posedge clk_in) tx_count_in <= 9'h000;
		tick(3);
		check_bit("tx ready", 1'b1, irq_out);
		pulse(6'h04);
		check_bit("tx write clears", 1'b0, irq_out);
		wr_reg(`UIP_OFF_FEATURE, 8'h20);
		@(posedge clk_in) tsr_empty_in <= 1'b0;
		tx_count_in <= 9'h001;
		@(posedge clk_in) tx_count_in <= 9'h000;
		tick(4);
		rd_chk(`UIP_OFF_SOURCE, 8'hC2);
		tick(2);
		rd_chk(`UIP_OFF_SOURCE, 8'hC1);
		@(posedge clk_in) tsr_empty_in <= 1'b1;
		tick(4);
		rd_chk(`UIP_OFF_SOURCE, 8'hC2);
		wr_reg(`UIP_OFF_MASK, 8'h01);
		wr_reg(`UIP_OFF_FEATURE, 8'h40);
		wr_reg(`UIP_OFF_FIFO_CTL, 8'h01);
		trig_chk(8);
		wr_reg(`UIP_OFF_FEATURE, 8'h80);
		wr_reg(`UIP_OFF_FIFO_CTL, 8'h81);
		trig_chk(56);
		wr_reg(`UIP_OFF_FEATURE, 8'hC0);
		wr_reg(`UIP_OFF_RX_TRIG, 8'h05);
		trig_chk(5);
		wr_reg(`UIP_OFF_FEATURE, 8'h00);
		wr_reg(`UIP_OFF_FIFO_CTL, 8'h41);
		seed = xs(seed);
		char_bits_in <= 4'h8 | {2'b00, seed[1:0]};
		lim = to_lim(8 + int'(seed[1:0]));
		@(posedge clk_in) rx_count_in <= 9'h001;
		tick_en <= 1'b1;
		n = 0;
		#1;
		while (irq_out !== 1'b1 && n <= lim + 20) begin
			tick(1);
			n++;
		end
		if (irq_out !== 1'b1) begin
			err_count++;
		end
		tick_en <= 1'b0;
		check_bit("timeout span", 1'b1, n >= lim && n <= lim + 6);
		rd_chk(`UIP_OFF_SOURCE, 8'hCC);
		pulse(6'h02);
		rd_chk(`UIP_OFF_SOURCE, 8'hC1);
		wr_reg(`UIP_OFF_ENHANCED, 8'h10);
		wr_reg(`UIP_OFF_MASK, 8'h20);
		pulse(6'h08);
		rd_chk(`UIP_OFF_SOURCE, 8'hD0);
		tick(2);
		rd_chk(`UIP_OFF_SOURCE, 8'hC1);
		wr_reg(`UIP_OFF_ENHANCED, 8'h50);
		wr_reg(`UIP_OFF_MASK, 8'h40);
		@(posedge clk_in) rts_state_in <= 1'b1;
		tick(4);
		rd_chk(`UIP_OFF_SOURCE, 8'hE0);
		rd_chk(`UIP_OFF_MODEM_STAT, {modem_state_in, 4'h0});
		tick(2);
		rd_chk(`UIP_OFF_SOURCE, 8'hC1);
		wr_reg(`UIP_OFF_ENHANCED, 8'h90);
		wr_reg(`UIP_OFF_MASK, 8'h80);
		@(posedge clk_in) cts_pin <= 1'b1;
		tick(8);
		rd_chk(`UIP_OFF_SOURCE, 8'hE0);
		rd_chk(`UIP_OFF_MODEM_STAT, {modem_state_in, 4'h0});
		tick(2);
		rd_chk(`UIP_OFF_SOURCE, 8'hC1);
		finish_test();
	end

endmodule : uip_prioritizer_bench

`default_nettype wire
